// ==== dv/sbhs_axis_model.sv ====
// Purpose: Behavioural servo axis with home switch and both limit switches.
// Assumes: Position moves FAST (8) or SLOW (1) counts per rising edge while motion is commanded.
// Notes:   Switch levels are pure functions of position, so each edge sits at a known place.
`timescale 1ns/10ps
`default_nettype none

module sbhs_axis_model #(
   parameter int unsigned POS_W   = 16,
   parameter int          HOME_LO = 1000,
   parameter int          HOME_HI = 1099,
   parameter int          POS_LIM = 1400,
   parameter int          NEG_LIM = 600,
   parameter int          FAST    = 8,
   parameter int          SLOW    = 1
   ) (
   input  wire logic             core_clk_in,
   input  wire logic             move_in,
   input  wire logic             dir_pos_in,
   input  wire logic             fast_in,
   input  wire logic             load_in,
   input  wire logic [POS_W-1:0] load_pos_in,
   output var  logic [POS_W-1:0] position_out,
   output var  logic             home_sw_out,
   output var  logic             pos_lim_out,
   output var  logic             neg_lim_out
   );
   int p;

   // --------------------------------------------------------------------------
   // Motion and switch geometry
   // --------------------------------------------------------------------------
   // The axis never stops on a limit by itself, so a missed reversal shows as a runaway.
   always_ff @(posedge core_clk_in) begin
      if (load_in) begin
         position_out <= load_pos_in;
      end else if (move_in) begin
         position_out <= dir_pos_in ? position_out + POS_W'(fast_in ? FAST : SLOW)
                                    : position_out - POS_W'(fast_in ? FAST : SLOW);
      end
   end

   assign p           = int'($signed(position_out));
   assign home_sw_out = (p >= HOME_LO) && (p <= HOME_HI);
   assign pos_lim_out = (p >= POS_LIM);
   assign neg_lim_out = (p <= NEG_LIM);
endmodule // sbhs_axis_model

`default_nettype wire

// ==== dv/sbhs_homing_seq_bench.sv ====
// Purpose: Self-checking bench of the homing sequencer against the axis model.
// Assumes: Inputs change at the falling edge; capture lands within four steps of a switch edge.
// Notes:   Home window 1000..1099, limits at 600 and 1400, fast step 8, slow step 1.
`timescale 1ns/10ps
`default_nettype none

module sbhs_homing_seq_bench;
   import sbhs_pkg::*;
   localparam int unsigned PW      = 16;
   localparam int          CYC_MAX = 20000;

   logic          clk    = 1'b0;
   logic          rst_n  = 1'b0;
   logic          en     = 1'b1;
   logic          cmd    = 1'b0;
   logic          load   = 1'b1;
   logic [5:0]    mode   = 6'h00;
   logic [PW-1:0] ld_pos = 16'h0320;
   logic [PW-1:0] pos;
   logic [PW-1:0] hp;
   logic          hsw, plim, nlim, mv, dirp, fst, dn, merr;
   int            fails     = 0;
   int            cmp_count = 0;
   int            cyc       = 0;

   always #20 clk = ~clk;

   sbhs_homing_seq #(.POS_W(PW)) uut (
      .core_clk_in(clk), .arst_n_in(rst_n), .clk_en_in(en), .homing_command_in(cmd), .mode_in(mode),
      .home_sw_in(hsw), .pos_lim_in(plim), .neg_lim_in(nlim), .position_in(pos), .move_out(mv),
      .dir_pos_out(dirp), .fast_out(fst), .done_out(dn), .mode_err_out(merr), .home_pos_out(hp));

   sbhs_axis_model #(.POS_W(PW)) axis (
      .core_clk_in(clk), .move_in(mv), .dir_pos_in(dirp), .fast_in(fst), .load_in(load),
      .load_pos_in(ld_pos), .position_out(pos), .home_sw_out(hsw), .pos_lim_out(plim), .neg_lim_out(nlim));

   // --------------------------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Start one homing run, then judge first phase, final phase and the captured position.
   task automatic run(input logic [5:0] m, input int start, input logic d0, input logic f0,
                      input logic d1, input logic f1, input int lo, input int hi);
      int         n;
      int         hs;
      logic [1:0] last;
      @(negedge clk);
      load   = 1'b1;
      ld_pos = start[PW-1:0];
      @(negedge clk);
      load = 1'b0;
      // Leave room for the switch pipeline to carry the new levels.
      repeat (4) @(negedge clk);
      cmd  = 1'b1;
      mode = m;
      @(negedge clk);
      chk(32'({mv, dirp, fst, merr}), 32'({1'b1, d0, f0, 1'b0}));
      // The command stays high while busy, now with a refused code, and must be ignored.
      mode = MODE_RSV_A;
      @(negedge clk);
      cmd = 1'b0;
      chk(32'({mv, merr}), 32'h2);
      n    = 0;
      last = 2'h0;
      do begin
         @(posedge clk);
         #1;
         n++;
         if (dn !== 1'b1) last = {dirp, fst};
      end while (dn !== 1'b1 && n < 3000);
      hs = int'($signed(hp));
      chk(32'({dn, mv}), 32'h2);
      chk(32'(last), 32'({d1, f1}));
      chk(32'(hs >= lo && hs <= hi), 32'h1);
      @(posedge clk);
      #1;
      chk(32'({dn, mv}), 32'h0);
   endtask

   // --------------------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------------------
   task automatic t_m17; run(MODE_17, 700, 0, 1, 1, 0, 601, 605); run(MODE_17, 590, 1, 0, 1, 0, 601, 605); endtask
   task automatic t_m18; run(MODE_18, 1300, 1, 1, 0, 0, 1395, 1399); run(MODE_18, 1410, 0, 0, 0, 0, 1395, 1399); endtask
   task automatic t_m19; run(MODE_19, 900, 1, 1, 0, 0, 995, 999); run(MODE_19, 1050, 0, 0, 0, 0, 995, 999); endtask
   task automatic t_m20; run(MODE_20, 900, 1, 1, 1, 1, 1000, 1032); run(MODE_20, 1050, 0, 0, 1, 0, 1000, 1004); endtask
   task automatic t_m21; run(MODE_21, 1050, 1, 0, 1, 0, 1100, 1104); run(MODE_21, 1200, 0, 1, 1, 0, 1100, 1104); endtask
   task automatic t_m22; run(MODE_22, 1050, 1, 0, 0, 0, 1095, 1099); run(MODE_22, 1200, 0, 1, 0, 1, 1067, 1099); endtask
   task automatic t_m23;
      run(MODE_23, 900, 1, 1, 0, 0, 995, 999);
      run(MODE_23, 1050, 0, 0, 0, 0, 995, 999);
      run(MODE_23, 1150, 1, 1, 0, 0, 995, 999);
   endtask
   task automatic t_m24;
      run(MODE_24, 900, 1, 1, 1, 1, 1000, 1032);
      run(MODE_24, 1050, 0, 0, 1, 0, 1000, 1004);
      run(MODE_24, 1150, 1, 1, 1, 1, 1000, 1032);
   endtask
   task automatic t_m25;
      run(MODE_25, 900, 1, 1, 0, 0, 1095, 1099);
      run(MODE_25, 1050, 1, 0, 0, 0, 1095, 1099);
      run(MODE_25, 1150, 1, 1, 0, 1, 1067, 1099);
   endtask

   // Reserved, index-pulse and out-of-range codes must be refused without motion.
   task automatic t_refused;
      logic [5:0] codes [5];
      codes = '{MODE_RSV_A, MODE_RSV_B, 6'h0E, 6'h1A, 6'h1E};
      // A low enable freezes the sequencer, so the command must not be taken.
      @(negedge clk);
      en   = 1'b0;
      cmd  = 1'b1;
      mode = MODE_RSV_A;
      @(negedge clk);
      chk(32'({mv, merr}), 32'h0);
      en  = 1'b1;
      cmd = 1'b0;
      foreach (codes[i]) begin
         @(negedge clk);
         cmd  = 1'b1;
         mode = codes[i];
         @(negedge clk);
         cmd = 1'b0;
         chk(32'({mv, merr}), 32'h1);
         @(negedge clk);
         chk(32'({mv, merr}), 32'h0);
      end
   endtask

   // A reset in mid-search must stop the axis and clear the captured position.
   task automatic t_reset_mid;
      @(negedge clk);
      load   = 1'b1;
      ld_pos = 16'h0384;
      @(negedge clk);
      load = 1'b0;
      repeat (4) @(negedge clk);
      cmd  = 1'b1;
      mode = MODE_19;
      @(negedge clk);
      cmd = 1'b0;
      repeat (4) @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      chk(32'({mv, dirp, fst, dn, merr}), 32'h0);
      chk(32'(hp), 32'h0);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == CYC_MAX) begin
         fails++;
         end_of_test();
      end
   end

   initial begin
      repeat (5) @(negedge clk);
      chk(32'({mv, dirp, fst, dn, merr}), 32'h0);
      chk(32'(hp), 32'h0);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_refused();
      t_reset_mid();
      t_m17();
      t_m18();
      t_m19();
      t_m20();
      t_m21();
      t_m22();
      t_m23();
      t_m24();
      t_m25();
      end_of_test();
   end
endmodule // sbhs_homing_seq_bench

`default_nettype wire

// ==== hw/sbhs_homing_seq.sv ====
// Purpose: Switch based homing sequencer for one servo axis, modes 17 to 25.
// Assumes: Position input is valid every cycle; switches are active high.
// Notes:   Other mode codes are refused; the error flag is set one cycle after each idle cycle the command is high with such a code.
`timescale 1ns/10ps
`default_nettype none

module sbhs_homing_seq
   import sbhs_pkg::*;
   #(
   parameter int unsigned POS_W = sbhs_pkg::POS_W_DEF
   ) (
   input  wire logic                        core_clk_in,
   input  wire logic                        arst_n_in,
   input  wire logic                        clk_en_in,
   input  wire logic                        homing_command_in,
   input  wire logic [sbhs_pkg::MODE_W-1:0] mode_in,
   input  wire logic                        home_sw_in,
   input  wire logic                        pos_lim_in,
   input  wire logic                        neg_lim_in,
   input  wire logic [POS_W-1:0]            position_in,
   output var  logic                        move_out,
   output var  logic                        dir_pos_out,
   output var  logic                        fast_out,
   output var  logic                        done_out,
   output var  logic                        mode_err_out,
   output var  logic [POS_W-1:0]            home_pos_out
   );

   // -----------------------------------------------------------------
   // Decoding helpers
   // -----------------------------------------------------------------

   // Modes 17 and 18 home on a limit switch, the rest on the home switch.
   function automatic logic [1:0] watch_sel(input logic [MODE_W-1:0] m);
      unique case (m)
         MODE_17: watch_sel = 2'(SW_NEG);
         MODE_18: watch_sel = 2'(SW_POS);
         default: watch_sel = 2'(SW_HOME);
      endcase
   endfunction

   function automatic logic known_mode(input logic [MODE_W-1:0] m);
      known_mode = (m >= MODE_17) && (m <= MODE_25);
   endfunction

   // Only modes 23 to 25 watch the positive limit during the fast search.
   function automatic logic lim_mode(input logic [MODE_W-1:0] m);
      lim_mode = (m >= MODE_23) && (m <= MODE_25);
   endfunction

   // -----------------------------------------------------------------
   // Switch synchroniser
   // -----------------------------------------------------------------

   sbhs_sw_if sw ();

   sbhs_sw_sync u_sync (
      .core_clk_in (core_clk_in),
      .arst_n_in   (arst_n_in),
      .clk_en_in   (clk_en_in),
      .raw_in      ({neg_lim_in, pos_lim_in, home_sw_in}),
      .sw          (sw.src)
   );

   // -----------------------------------------------------------------
   // Sequencer state
   // -----------------------------------------------------------------

   sbhs_state_t       state;
   sbhs_state_t       next_state;
   logic [MODE_W-1:0] mode;
   logic              next_dir_pos;
   logic              next_fast;
   logic              next_move;
   logic              cap;
   logic              start_err;
   logic [1:0]        wsel;
   logic [1:0]        start_sel;
   logic              w_rise;
   logic              w_fall;
   logic              start_on;
   logic              lim_hit;
   logic              start;

   assign start     = (state == ST_IDLE) && homing_command_in;
   assign wsel      = watch_sel(mode);
   assign start_sel = watch_sel(mode_in);
   assign start_on  = sw.lvl[start_sel];

   // The index pulse has no input here at all.
   assign w_rise = sw.rise[wsel];
   assign w_fall = sw.fall[wsel];

   // The limit only counts while still searching outward at fast speed.
   assign lim_hit = lim_mode(mode) && dir_pos_out && fast_out && sw.rise[SW_POS];

   // -----------------------------------------------------------------
   // Next-state decision
   // -----------------------------------------------------------------

   always_comb begin
      next_state   = state;
      next_dir_pos = dir_pos_out;
      next_fast    = fast_out;
      next_move    = move_out;
      cap          = 1'b0;
      start_err    = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (homing_command_in) begin
               if (!known_mode(mode_in)) begin
                  start_err = 1'b1;
               end else begin
                  next_move = 1'b1;
                  // Every supported mode starts slow when its switch is already on.
                  next_fast = ~start_on;
                  unique case (mode_in)
                     MODE_17: begin
                        next_dir_pos = start_on;
                        next_state   = start_on ? ST_CAP_OFF : ST_FIND_ON;
                     end
                     MODE_18: begin
                        next_dir_pos = ~start_on;
                        next_state   = start_on ? ST_CAP_OFF : ST_FIND_ON;
                     end
                     MODE_19, MODE_23: begin
                        next_dir_pos = ~start_on;
                        next_state   = start_on ? ST_CAP_OFF : ST_FIND_ON;
                     end
                     MODE_21: begin
                        next_dir_pos = start_on;
                        next_state   = start_on ? ST_CAP_OFF : ST_FIND_ON;
                     end
                     MODE_20, MODE_24: begin
                        next_dir_pos = ~start_on;
                        next_state   = start_on ? ST_LEAVE : ST_CAP_ON;
                     end
                     MODE_22: begin
                        next_dir_pos = start_on;
                        next_state   = start_on ? ST_LEAVE : ST_CAP_ON;
                     end
                     default: begin
                        next_dir_pos = 1'b1;
                        next_state   = start_on ? ST_LEAVE : ST_WAIT_ON;
                     end
                  endcase
               end
            end
         end
         ST_FIND_ON: begin
            if (w_rise) begin
               next_dir_pos = ~dir_pos_out;
               next_fast    = 1'b0;
               next_state   = ST_CAP_OFF;
            end else if (lim_hit) begin
               next_dir_pos = 1'b0;
               next_state   = ST_WAIT_ON;
            end
         end
         ST_CAP_OFF: begin
            if (w_fall) begin
               cap        = 1'b1;
               next_move  = 1'b0;
               next_state = ST_IDLE;
            end
         end
         ST_CAP_ON: begin
            if (w_rise) begin
               cap        = 1'b1;
               next_move  = 1'b0;
               next_state = ST_IDLE;
            end else if (lim_hit) begin
               next_dir_pos = 1'b0;
               next_state   = ST_WAIT_ON;
            end
         end
         ST_LEAVE: begin
            if (w_fall) begin
               // The reversal keeps whatever speed the search had.
               next_dir_pos = ~dir_pos_out;
               next_state   = ST_CAP_ON;
            end
         end
         ST_WAIT_ON: begin
            if (w_rise) begin
               next_fast  = (mode == MODE_24);
               next_state = (mode == MODE_23) ? ST_CAP_OFF : ST_LEAVE;
            end else if (lim_hit) begin
               next_dir_pos = 1'b0;
               next_state   = ST_CAP_ON;
            end
         end
         default: begin
            next_move  = 1'b0;
            next_state = ST_IDLE;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= ST_IDLE;
      end else if (clk_en_in) begin
         state <= next_state;
      end
   end

   // The mode is frozen at the command so a change mid-run cannot confuse the walk.
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mode <= 6'h00;
      end else if (clk_en_in && start) begin
         mode <= mode_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         move_out    <= 1'b0;
         dir_pos_out <= 1'b0;
         fast_out    <= 1'b0;
      end else if (clk_en_in) begin
         move_out    <= next_move;
         dir_pos_out <= next_dir_pos;
         fast_out    <= next_fast;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         done_out     <= 1'b0;
         mode_err_out <= 1'b0;
      end else if (clk_en_in) begin
         done_out     <= cap;
         mode_err_out <= start_err;
      end
   end

   sbhs_pos_latch #(
      .W (POS_W)
   ) u_latch (
      .core_clk_in  (core_clk_in),
      .arst_n_in    (arst_n_in),
      .clk_en_in    (clk_en_in),
      .cap_in       (cap),
      .pos_in       (position_in),
      .home_pos_out (home_pos_out)
   );

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);

   property p_reserved;
      clk_en_in && start && (mode_in == MODE_RSV_A || mode_in == MODE_RSV_B)
         |=> mode_err_out && !move_out && state == ST_IDLE;
   endproperty
   a_reserved: assert property (p_reserved) else $error("Reserved mode started motion.");

   // Judged against the mode itself so that a wrong watch selection cannot hide.
   property p_switch_only;
      clk_en_in && cap |->
         ((mode == MODE_17) ? sw.fall[SW_NEG] :
          (mode == MODE_18) ? sw.fall[SW_POS] : (sw.rise[SW_HOME] || sw.fall[SW_HOME]));
   endproperty
   a_switch_only: assert property (p_switch_only) else $error("Capture without switch edge.");

   property p_m17_off;
      clk_en_in && start && mode_in == MODE_17 && !sw.lvl[SW_NEG]
         |=> move_out && !dir_pos_out && fast_out;
   endproperty
   a_m17_off: assert property (p_m17_off) else $error("Mode 17 search start wrong.");

   property p_m17_on;
      clk_en_in && start && mode_in == MODE_17 && sw.lvl[SW_NEG]
         |=> dir_pos_out && !fast_out && state == ST_CAP_OFF;
   endproperty
   a_m17_on: assert property (p_m17_on) else $error("Mode 17 leave start wrong.");

   property p_m18_rev;
      clk_en_in && state == ST_FIND_ON && mode == MODE_18 && sw.rise[SW_POS]
         |=> !dir_pos_out && !fast_out && state == ST_CAP_OFF;
   endproperty
   a_m18_rev: assert property (p_m18_rev) else $error("Mode 18 reversal wrong.");

   property p_m18_on;
      clk_en_in && start && mode_in == MODE_18 && sw.lvl[SW_POS]
         |=> !dir_pos_out && !fast_out;
   endproperty
   a_m18_on: assert property (p_m18_on) else $error("Mode 18 leave start wrong.");

   property p_m19_rev;
      clk_en_in && state == ST_FIND_ON && mode == MODE_19 && sw.rise[SW_HOME]
         |=> !dir_pos_out && !fast_out && state == ST_CAP_OFF;
   endproperty
   a_m19_rev: assert property (p_m19_rev) else $error("Mode 19 reversal wrong.");

   property p_m20_off;
      clk_en_in && start && mode_in == MODE_20 && !sw.lvl[SW_HOME]
         |=> move_out && dir_pos_out && fast_out && state == ST_CAP_ON;
   endproperty
   a_m20_off: assert property (p_m20_off) else $error("Mode 20 search start wrong.");

   property p_m22_on;
      clk_en_in && start && mode_in == MODE_22 && sw.lvl[SW_HOME]
         |=> move_out && dir_pos_out && !fast_out && state == ST_LEAVE;
   endproperty
   a_m22_on: assert property (p_m22_on) else $error("Mode 22 leave start wrong.");

   property p_m25_slow;
      clk_en_in && state == ST_WAIT_ON && mode == MODE_25 && sw.rise[SW_HOME]
         |=> dir_pos_out && !fast_out && state == ST_LEAVE;
   endproperty
   a_m25_slow: assert property (p_m25_slow) else $error("Mode 25 slow-down wrong.");

   property p_m23_lim;
      clk_en_in && state == ST_FIND_ON && mode == MODE_23 && !w_rise && lim_hit
         |=> !dir_pos_out && fast_out && state == ST_WAIT_ON;
   endproperty
   a_m23_lim: assert property (p_m23_lim) else $error("Mode 23 limit reversal wrong.");

   property p_m24_fast;
      clk_en_in && state == ST_WAIT_ON && mode == MODE_24 && w_rise
         |=> fast_out && state == ST_LEAVE;
   endproperty
   a_m24_fast: assert property (p_m24_fast) else $error("Mode 24 lost fast speed.");

   property p_capture;
      clk_en_in && cap |=> done_out && !move_out && home_pos_out == $past(position_in);
   endproperty
   a_capture: assert property (p_capture) else $error("Capture did not latch and stop.");

   property p_done_idle;
      done_out |-> state == ST_IDLE && !move_out;
   endproperty
   a_done_idle: assert property (p_done_idle) else $error("Done while still moving.");

   c_done:     cover property (clk_en_in && cap);
   c_reserved: cover property (clk_en_in && start_err);
   c_limit:    cover property (clk_en_in && lim_hit && state == ST_CAP_ON);
   c_m25_lim:  cover property (clk_en_in && lim_hit && state == ST_WAIT_ON);

endmodule // sbhs_homing_seq

`default_nettype wire

// ==== hw/sbhs_pkg.sv ====
// Contract
// - Mode codes 15 and 16 are reserved and start no homing motion.
// - Modes 17 to 30 never use the index pulse, only switch levels and edges; modes 26 to 30 are refused here.
// - Mode 17, negative limit off: fast negative, limit on reverses slow, capture off.
// - Mode 17, negative limit on: slow positive, capture when it goes off.
// - Mode 18, positive limit off: fast positive, limit on reverses slow, capture off.
// - Mode 18, positive limit on: slow negative, capture when it goes off.
// - Mode 19: home off fast positive, reverse slow on; home on slow negative; capture off.
// - Mode 20: home off fast positive, capture on; home on slow negative, reverse, capture on.
// - Mode 21: home on slow positive; off fast negative, reverse slow on; capture off.
// - Mode 22, home on: slow positive, reverse slow at off, capture at on.
// - Mode 22, home off: fast negative, capture when home turns on.
// - Mode 23: home off fast positive, reverse slow on; home on slow negative; capture off.
// - Mode 23, positive limit first: reverse fast, slow at home on, capture at off.
// - Mode 24: like mode 20 with positive limit watch during fast search.
// - Mode 24, positive limit first: reverse fast, stay fast, reverse at off, capture on.
// - Mode 25: positive, slow once home on, reverse at off, capture at on.
// - Mode 25, positive limit first: reverse fast, capture when home turns on.
//
// Purpose: Shared constants and types of the switch based homing sequencer.
// Assumes: One clock domain; switch inputs are active high levels.
// Notes:   Switch index order is home, positive limit, negative limit.

package sbhs_pkg;

   localparam int unsigned MODE_W    = 6;
   localparam int unsigned POS_W_DEF = 32;
   localparam int unsigned SW_N      = 3;

   localparam int unsigned SW_HOME = 0;
   localparam int unsigned SW_POS  = 1;
   localparam int unsigned SW_NEG  = 2;

   localparam logic [5:0] MODE_RSV_A = 6'h0F;
   localparam logic [5:0] MODE_RSV_B = 6'h10;
   localparam logic [5:0] MODE_17    = 6'h11;
   localparam logic [5:0] MODE_18    = 6'h12;
   localparam logic [5:0] MODE_19    = 6'h13;
   localparam logic [5:0] MODE_20    = 6'h14;
   localparam logic [5:0] MODE_21    = 6'h15;
   localparam logic [5:0] MODE_22    = 6'h16;
   localparam logic [5:0] MODE_23    = 6'h17;
   localparam logic [5:0] MODE_24    = 6'h18;
   localparam logic [5:0] MODE_25    = 6'h19;

   // Enabled edges after reset before switch edges are trusted.
   localparam logic [1:0] SETTLE_CYC = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_FIND_ON = 3'b001,
      ST_CAP_OFF = 3'b010,
      ST_CAP_ON  = 3'b011,
      ST_LEAVE   = 3'b100,
      ST_WAIT_ON = 3'b101
   } sbhs_state_t;

endpackage

// ==== hw/sbhs_pos_latch.sv ====
// Purpose: Holds the captured home position.
// Assumes: The capture strobe is one enabled cycle wide.
// Notes:   Keeps its value until the next capture or a reset, which clears it.
`timescale 1ns/10ps
`default_nettype none

module sbhs_pos_latch #(
   parameter int unsigned W = 32
   ) (
   input  wire logic         core_clk_in,
   input  wire logic         arst_n_in,
   input  wire logic         clk_en_in,
   input  wire logic         cap_in,
   input  wire logic [W-1:0] pos_in,
   output var  logic [W-1:0] home_pos_out
   );

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         home_pos_out <= '0;
      end else if (clk_en_in && cap_in) begin
         home_pos_out <= pos_in;
      end
   end

endmodule // sbhs_pos_latch

`default_nettype wire

// ==== hw/sbhs_sw_if.sv ====
// Purpose: Carries synchronised switch levels and edge events.
// Assumes: Bit order follows the switch indices of the package.
// Notes:   Edges are one enabled cycle wide.
`timescale 1ns/10ps
`default_nettype none

interface sbhs_sw_if;
   logic [2:0] lvl;
   logic [2:0] rise;
   logic [2:0] fall;

   modport src (output lvl, output rise, output fall);
   modport dst (input lvl, input rise, input fall);
endinterface

`default_nettype wire

// ==== hw/sbhs_sw_sync.sv ====
// Purpose: Two-stage synchroniser and edge detector for the three switches.
// Assumes: Raw switch levels may change at any time.
// Notes:   Edges are held back until the pipeline has filled after reset.
`timescale 1ns/10ps
`default_nettype none

module sbhs_sw_sync
   import sbhs_pkg::*;
   (
   input  wire logic                      core_clk_in,
   input  wire logic                      arst_n_in,
   input  wire logic                      clk_en_in,
   input  wire logic [sbhs_pkg::SW_N-1:0] raw_in,
   sbhs_sw_if.src                         sw
   );

   logic [SW_N-1:0] meta;
   logic [SW_N-1:0] sync;
   logic [SW_N-1:0] prev;
   logic [1:0]      settle;
   logic            primed;

   // The first stage feeds only the second stage.
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta <= 3'h0;
         sync <= 3'h0;
         prev <= 3'h0;
      end else if (clk_en_in) begin
         meta <= raw_in;
         sync <= meta;
         prev <= sync;
      end
   end

   // Without this a switch that is on at reset would look like a fresh edge.
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         settle <= 2'h0;
      end else if (clk_en_in && !primed) begin
         settle <= settle + 2'h1;
      end
   end

   assign primed  = (settle == SETTLE_CYC);
   assign sw.lvl  = sync;
   assign sw.rise = primed ? (sync & ~prev) : 3'h0;
   assign sw.fall = primed ? (~sync & prev) : 3'h0;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);

   property p_edge_once;
      clk_en_in && (sw.rise != 3'h0) |=> (sw.rise & $past(sw.rise)) == 3'h0;
   endproperty
   a_edge_once: assert property (p_edge_once) else $error("Switch edge reported twice.");

endmodule // sbhs_sw_sync

`default_nettype wire
